// ==== hw/bmv_cfg.svh ====
// Purpose: Offsets, field positions, codes and timing counts of the bridge
//          mode and vendor command logic.
// Assumes: 100 MHz ref_clk.
// Notes:   Definitions only.
`ifndef BMV_CFG_SVH
`define BMV_CFG_SVH

// ****************************************************************
// EEPROM start-up signature
// ****************************************************************
`define BMV_SIG_VALUE      8'h4d
`define BMV_EE_SIG0_ADDR   8'h00
`define BMV_EE_SIG1_ADDR   8'h01
`define BMV_EE_DESIG_ADDR  8'h04

// ****************************************************************
// Vendor command block codes
// ****************************************************************
`define BMV_SUB_EEPROM     8'h26
`define BMV_SUB_BOARD      8'h27
`define BMV_EE_MAX_LEN     32'h0000_00ff
`define BMV_LOAD_BYTES     32'h0000_0007
`define BMV_SAMPLE_BYTES   32'h0000_0008

// ****************************************************************
// Command block wrapper byte positions
// ****************************************************************
`define BMV_CBW_LEN_FIRST  5'h08
`define BMV_CBW_LEN_LAST   5'h0b
`define BMV_CBW_FLAGS      5'h0c
`define BMV_CBW_DIR_BIT    7
`define BMV_CBW_CB_FIRST   5'h0f
`define BMV_CBW_CB_SUB     5'h10
`define BMV_CBW_CB_LAST    5'h1e

// ****************************************************************
// Timing
// ****************************************************************
`define BMV_CLK_HZ         100000000
`define BMV_SAMPLE_HZ      60
`define BMV_SAMPLE_CYCLES  (`BMV_CLK_HZ / `BMV_SAMPLE_HZ)
`define BMV_RESET_HOLD_MS  10

`endif

// ==== hw/bmv_pkg.sv ====
// Purpose: Types of the bridge mode and vendor command logic.
// Assumes: Nothing.
// Notes:   Constants live in bmv_cfg.svh.
package bmv_pkg;

  typedef enum logic [1:0] {
    BMV_BOOT_REQ,
    BMV_BOOT_WAIT,
    BMV_BOOT_DONE
  } bmv_boot_type;

endpackage

// ==== hw/bmv_tick.sv ====
// Purpose: Divider giving a one-cycle enable pulse every PERIOD cycles.
// Assumes: PERIOD of at least 1.
// Notes:   Used for the enable pin sampling rate.
`timescale 1ns/1ps
`default_nettype none

module bmv_tick #(
  parameter int unsigned PERIOD = 1666666
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Enable pulse
  output logic      tick_r
);

  logic [31:0] cnt_r;
  wire         wrap = (cnt_r == 32'(PERIOD - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
      tick_r <= wrap;
    end
  end

endmodule // bmv_tick

`default_nettype wire

// ==== hw/bmv_cbw_decode.sv ====
// Purpose: Pulls length, direction, designator and subcommand out of a
//          command block wrapper arriving one byte a cycle.
// Assumes: cbw_start marks byte 0; bytes follow in order.
// Notes:   Bytes past the block field are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "bmv_cfg.svh"

module bmv_cbw_decode (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Wrapper byte stream
  input  wire logic        cbw_start,
  input  wire logic        cbw_valid,
  input  wire logic [7:0]  cbw_byte,
  // Decoded fields
  output logic             cb_ready_r,
  output logic [31:0]      cb_len_r,
  output logic             cb_dir_in_r,
  output logic [7:0]       cb_desig_r,
  output logic [7:0]       cb_sub_r
);

  logic [4:0] idx_r;

  function automatic logic at_idx(input logic [4:0] i, input logic [4:0] p);
    at_idx = (i == p);
  endfunction

  wire [4:0] idx_now  = cbw_start ? 5'h00 : idx_r;
  wire       take     = cbw_valid && (cbw_start || idx_r != 5'h1f);
  wire       in_len   = (idx_now >= `BMV_CBW_LEN_FIRST) &&
                        (idx_now <= `BMV_CBW_LEN_LAST);
  wire [1:0] len_lane = 2'(idx_now - `BMV_CBW_LEN_FIRST);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r       <= 5'h1f;
      cb_ready_r  <= 1'b0;
      cb_len_r    <= 32'h0000_0000;
      cb_dir_in_r <= 1'b0;
      cb_desig_r  <= 8'h00;
      cb_sub_r    <= 8'h00;
    end else begin
      cb_ready_r <= take && at_idx(idx_now, `BMV_CBW_CB_LAST); // [RULE11]
      if (take) begin
        idx_r <= idx_now + 5'h01;
        if (in_len) begin
          cb_len_r[len_lane*8 +: 8] <= cbw_byte; // [RULE16]
        end
        if (at_idx(idx_now, `BMV_CBW_FLAGS)) begin
          cb_dir_in_r <= cbw_byte[`BMV_CBW_DIR_BIT]; // [RULE17]
        end
        if (at_idx(idx_now, `BMV_CBW_CB_FIRST)) begin
          cb_desig_r <= cbw_byte; // [RULE12]
        end
        if (at_idx(idx_now, `BMV_CBW_CB_SUB)) begin
          cb_sub_r <= cbw_byte;
        end
      end
    end
  end

endmodule // bmv_cbw_decode

`default_nettype wire

// ==== hw/bmv_top.sv ====
// Purpose: Start-up mode choice, bus enable handling and vendor command
//          decode of a USB to ATA bridge.
// Assumes: EEPROM reads, wrapper bytes and load data come from logic on
//          ref_clk; pins are synchronised here.
// Notes:   The two-wire engine and ATA engine sit outside this block.
//
// Notes on behaviour
// [RULE1] Enable pin is sampled sixty times a second to spot level changes.
// [RULE2] While enable is high the ATA interface runs normally.
// [RULE3] On a fall: float ATA pins, detach USB, idle until reset or rise.
// [RULE4] On a rise: restart to post-reset state and reattach USB.
// [RULE5] Outside system keeps enable high at start and during transfers.
// [RULE6] Holding the active-low reset 10 ms resets the whole block.
// [RULE7] Full and high speed only; low speed is never offered.
// [RULE8] Both first EEPROM bytes 0x4d select normal, EEPROM-configured use.
// [RULE9] No EEPROM answer or bad signature selects board test mode.
// [RULE10] Test mode enumerates but keeps ATA idle; only vendor commands.
// [RULE11] Vendor blocks ride in wrapper bytes 15 to 30.
// [RULE12] Block byte 0 must match designator read from EEPROM byte 4.
// [RULE13] Subcommand 0x26 marks the EEPROM access block.
// [RULE14] Host sets source 0x02, start address zero, other bytes zero.
// [RULE15] EEPROM transfers are at most 255 bytes in the set layout.
// [RULE16] Data length comes from wrapper bytes 8 to 11.
// [RULE17] Direction comes from wrapper byte 12 bit 7.
// [RULE18] Subcommand 0x27 marks the board test block; rest zero.
// [RULE19] Pin drive takes seven bytes; only a hard reset ends it.
// [RULE20] Pin sample returns eight bytes of pin levels, reserved as zero.
// [RULE21] Unknown designator or subcommand fails the command.
`timescale 1ns/1ps
`default_nettype none
`include "bmv_cfg.svh"

module bmv_top #(
  parameter int unsigned SAMPLE_CYCLES = `BMV_SAMPLE_CYCLES,
  parameter logic [7:0]  DEFAULT_DESIG = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Bus enable pin
  input  wire logic        ata_bus_enable_in,
  // Start-up EEPROM byte reads
  output logic             ee_rd_req_r,
  output logic [7:0]       ee_rd_addr_r,
  input  wire logic        ee_rd_done,
  input  wire logic        ee_rd_ack,
  input  wire logic [7:0]  ee_rd_data,
  // Command block wrapper bytes
  input  wire logic        cbw_start,
  input  wire logic        cbw_valid,
  input  wire logic [7:0]  cbw_byte,
  // Pin drive data from the host
  input  wire logic        load_valid,
  input  wire logic [7:0]  load_byte,
  // Sampled pins
  input  wire logic        intrq_in,
  input  wire logic        vbus_valid_in,
  input  wire logic        iordy_in,
  input  wire logic        dmarq_in,
  input  wire logic [15:0] dd_in,
  // Mode and link state
  output logic             normal_mode_r,
  output logic             test_mode_r,
  output logic             usb_attach_r,
  output logic [1:0]       usb_speed_cap_r,
  output logic             ata_run_r,
  output logic             ata_float_r,
  output logic             restart_r,
  output logic [7:0]       desig_r,
  // Vendor command results
  output logic             vcmd_eeprom_go_r,
  output logic             vcmd_load_go_r,
  output logic             vcmd_sample_go_r,
  output logic             vcmd_fail_r,
  output logic             vcmd_dir_in_r,
  output logic [7:0]       vcmd_len_r,
  // Board test pins
  output logic             test_drive_r,
  output logic [15:0]      test_ctrl_r,
  output logic [15:0]      test_dd_out_r,
  output logic             test_dd_oe_r,
  output logic [63:0]      snapshot_r
);

  // ****************************************************************
  // Pin synchronisers and sampling
  // ****************************************************************
  default clocking chk_clk @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic        en_s1_r, en_s2_r, en_smp_r;
  logic [19:0] pin_s1_r, pin_s2_r;
  logic        link_idle_r;
  logic        tick;

  bmv_tick #(.PERIOD(SAMPLE_CYCLES)) bmv_tick_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .tick_r(tick));

  wire en_fall = tick && en_smp_r && !en_s2_r;   // [RULE1]
  wire en_rise = tick && !en_smp_r && en_s2_r;   // [RULE1]

  // Reset value high: the outside system holds the pin high at start-up
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_s1_r  <= 1'b1;
      en_s2_r  <= 1'b1;
      en_smp_r <= 1'b1; // [RULE5]
      pin_s1_r <= 20'h00000;
      pin_s2_r <= 20'h00000;
    end else begin
      en_s1_r  <= ata_bus_enable_in;
      en_s2_r  <= en_s1_r;
      pin_s1_r <= {intrq_in, vbus_valid_in, iordy_in, dmarq_in, dd_in};
      pin_s2_r <= pin_s1_r;
      if (tick) begin
        en_smp_r <= en_s2_r; // [RULE1]
      end
    end
  end

  a_sample_on_tick: assert property ( // [RULE1]
    (en_smp_r != $past(en_smp_r)) |-> $past(tick))
    else $error("enable level taken outside a sample tick");

  // ****************************************************************
  // Start-up signature read
  // ****************************************************************
  bmv_pkg::bmv_boot_type boot_r;
  logic [7:0]            sig0_r, sig1_r;

  wire rd_fin    = (boot_r == bmv_pkg::BMV_BOOT_WAIT) && ee_rd_done;
  wire rd_nack   = rd_fin && !ee_rd_ack;
  wire rd_last   = rd_fin && (ee_rd_addr_r == `BMV_EE_DESIG_ADDR);
  wire sig_ok    = (sig0_r == `BMV_SIG_VALUE) && (sig1_r == `BMV_SIG_VALUE);
  wire boot_fin  = rd_nack || rd_last;
  wire [7:0] next_addr = (ee_rd_addr_r == `BMV_EE_SIG0_ADDR) ?
                         `BMV_EE_SIG1_ADDR : `BMV_EE_DESIG_ADDR;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin // [RULE6]
      boot_r       <= bmv_pkg::BMV_BOOT_REQ;
      ee_rd_req_r  <= 1'b0;
      ee_rd_addr_r <= `BMV_EE_SIG0_ADDR;
      sig0_r       <= 8'h00;
      sig1_r       <= 8'h00;
      desig_r      <= DEFAULT_DESIG;
      normal_mode_r <= 1'b0;
      test_mode_r  <= 1'b0;
    end else begin
      ee_rd_req_r <= 1'b0;
      case (boot_r)
        bmv_pkg::BMV_BOOT_REQ: begin
          ee_rd_req_r <= 1'b1;
          boot_r      <= bmv_pkg::BMV_BOOT_WAIT;
        end
        bmv_pkg::BMV_BOOT_WAIT: begin
          if (rd_fin && ee_rd_ack) begin
            if (ee_rd_addr_r == `BMV_EE_SIG0_ADDR) sig0_r <= ee_rd_data;
            if (ee_rd_addr_r == `BMV_EE_SIG1_ADDR) sig1_r <= ee_rd_data;
            if (rd_last) desig_r <= ee_rd_data; // [RULE12]
          end
          if (boot_fin) begin
            boot_r        <= bmv_pkg::BMV_BOOT_DONE;
            normal_mode_r <= !rd_nack && sig_ok;       // [RULE8]
            test_mode_r   <= rd_nack || !sig_ok;       // [RULE9]
          end else if (rd_fin) begin
            ee_rd_addr_r <= next_addr;
            boot_r       <= bmv_pkg::BMV_BOOT_REQ;
          end
        end
        bmv_pkg::BMV_BOOT_DONE: boot_r <= bmv_pkg::BMV_BOOT_DONE;
        default: boot_r <= bmv_pkg::BMV_BOOT_REQ;
      endcase
    end
  end

  a_sig_normal: assert property ( // [RULE8]
    $rose(normal_mode_r) |-> sig0_r == 8'h4d && sig1_r == 8'h4d)
    else $error("normal mode without valid signature");
  a_nack_test: assert property ( // [RULE9]
    rd_nack |=> test_mode_r && !normal_mode_r)
    else $error("missing EEPROM did not select test mode");

  // ****************************************************************
  // Link state and ATA pin control
  // ****************************************************************
  wire booted        = (boot_r == bmv_pkg::BMV_BOOT_DONE);
  wire idle_nxt      = (link_idle_r || en_fall) && !en_rise;      // [RULE3]
  wire attach_nxt    = booted && !idle_nxt;                       // [RULE4]
  // ATA runs only in normal mode; test mode enumerates with ATA quiet
  wire run_nxt       = booted && normal_mode_r && !idle_nxt;      // [RULE2]
  wire float_nxt     = !run_nxt && !test_drive_r;                 // [RULE10]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_idle_r     <= 1'b0;
      usb_attach_r    <= 1'b0;
      ata_run_r       <= 1'b0;
      ata_float_r     <= 1'b1;
      restart_r       <= 1'b0;
      usb_speed_cap_r <= 2'b00;
    end else begin
      link_idle_r     <= idle_nxt;
      usb_attach_r    <= attach_nxt;
      ata_run_r       <= run_nxt;
      ata_float_r     <= float_nxt || idle_nxt; // [RULE3]
      restart_r       <= en_rise;               // [RULE4]
      usb_speed_cap_r <= 2'b11;                 // [RULE7]
    end
  end

  a_fall_floats: assert property ( // [RULE3]
    en_fall |=> ata_float_r && !usb_attach_r && !ata_run_r)
    else $error("fall of enable did not float and detach");
  a_idle_holds: assert property ( // [RULE3]
    link_idle_r && !en_rise |=> !usb_attach_r)
    else $error("idle link reattached without a rise");
  a_rise_restart: assert property ( // [RULE4]
    en_rise && booted |=> restart_r && usb_attach_r ##1 !restart_r)
    else $error("rise of enable did not restart and reattach");
  a_run_normal: assert property ( // [RULE2]
    ata_run_r |-> normal_mode_r && !link_idle_r && !ata_float_r)
    else $error("ATA running outside normal enabled state");
  a_test_ata_quiet: assert property ( // [RULE10]
    test_mode_r |-> !ata_run_r)
    else $error("ATA running in board test mode");

  // ****************************************************************
  // Vendor command decode
  // ****************************************************************
  logic        cb_ready, cb_dir_in;
  logic [31:0] cb_len;
  logic [7:0]  cb_desig, cb_sub;

  bmv_cbw_decode bmv_cbw_decode_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .cbw_start(cbw_start), .cbw_valid(cbw_valid), .cbw_byte(cbw_byte),
    .cb_ready_r(cb_ready), .cb_len_r(cb_len), .cb_dir_in_r(cb_dir_in),
    .cb_desig_r(cb_desig), .cb_sub_r(cb_sub));

  // Host-side byte 2..15 contents are not checked; host fills them as [RULE14] and [RULE18] say
  wire desig_ok  = (cb_desig == desig_r);                          // [RULE12]
  wire is_ee     = desig_ok && (cb_sub == `BMV_SUB_EEPROM);        // [RULE13]
  wire is_board  = desig_ok && (cb_sub == `BMV_SUB_BOARD);         // [RULE18]
  wire ee_ok     = is_ee && (cb_len <= `BMV_EE_MAX_LEN);           // [RULE15]
  wire load_ok   = is_board && test_mode_r && !cb_dir_in &&
                   (cb_len == `BMV_LOAD_BYTES);                    // [RULE19]
  wire samp_ok   = is_board && test_mode_r && cb_dir_in &&
                   (cb_len == `BMV_SAMPLE_BYTES);                  // [RULE20]
  wire cmd_ok    = ee_ok || load_ok || samp_ok;

  logic       load_act_r;
  logic [2:0] load_cnt_r;
  logic [7:0] load_buf [0:6];

  wire load_take = load_act_r && load_valid;
  wire load_end  = load_take && (load_cnt_r == 3'h6);

  // Pin snapshot; reserved bits read as zero
  wire [63:0] snap_nxt = {32'h0000_0000,
                          pin_s2_r[15:8], pin_s2_r[7:0],
                          test_dd_oe_r, 1'b0, en_s2_r, pin_s2_r[16],
                          pin_s2_r[17], 3'b000,
                          test_ctrl_r[7], pin_s2_r[18], 5'b00000,
                          pin_s2_r[19]};                           // [RULE20]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcmd_eeprom_go_r <= 1'b0;
      vcmd_load_go_r   <= 1'b0;
      vcmd_sample_go_r <= 1'b0;
      vcmd_fail_r      <= 1'b0;
      vcmd_dir_in_r    <= 1'b0;
      vcmd_len_r       <= 8'h00;
      snapshot_r       <= 64'h0000_0000_0000_0000;
    end else begin
      vcmd_eeprom_go_r <= cb_ready && ee_ok;
      vcmd_load_go_r   <= cb_ready && load_ok;
      vcmd_sample_go_r <= cb_ready && samp_ok;
      vcmd_fail_r      <= cb_ready && !cmd_ok;   // [RULE21]
      if (cb_ready) begin
        vcmd_dir_in_r <= cb_dir_in;              // [RULE17]
        vcmd_len_r    <= cb_len[7:0];            // [RULE16]
      end
      if (cb_ready && samp_ok) begin
        snapshot_r <= snap_nxt;
      end
    end
  end

  a_unknown_fails: assert property ( // [RULE21]
    cb_ready && !is_ee && !is_board |=> vcmd_fail_r && !vcmd_eeprom_go_r)
    else $error("unknown vendor block not failed");
  a_ee_len_cap: assert property ( // [RULE15]
    cb_ready && is_ee && cb_len > `BMV_EE_MAX_LEN |=> vcmd_fail_r)
    else $error("oversize EEPROM transfer accepted");

  // ****************************************************************
  // Pin drive load
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (load_take) begin
      load_buf[load_cnt_r] <= load_byte;
    end
  end

  // Once driving, only the asynchronous reset gives the pins back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_act_r    <= 1'b0;
      load_cnt_r    <= 3'h0;
      test_drive_r  <= 1'b0;
      test_ctrl_r   <= 16'h0000;
      test_dd_out_r <= 16'h0000;
      test_dd_oe_r  <= 1'b0;
    end else begin
      if (cb_ready && load_ok) begin
        load_act_r <= 1'b1;
        load_cnt_r <= 3'h0;
      end else if (load_take) begin
        load_act_r <= !load_end;
        load_cnt_r <= load_cnt_r + 3'h1;
      end
      if (load_end) begin
        test_drive_r  <= 1'b1;                                // [RULE19]
        test_ctrl_r   <= {load_buf[1], load_buf[0]};
        test_dd_out_r <= {load_buf[3], load_buf[2]};
        test_dd_oe_r  <= load_buf[1][7];
      end
    end
  end

  a_drive_sticks: assert property ( // [RULE19]
    $rose(test_drive_r) |=> test_drive_r [*8])
    else $error("pin drive mode left without reset");

endmodule // bmv_top

`default_nettype wire

// ==== hw/bmv_top_fix.sv ====
`timescale 1ns/1ps

// ==== bench/bmv_ee_model.sv ====
// Purpose: Start-up EEPROM read engine model answering byte reads.
// Assumes: One read pending at a time.
// Notes:   Data shows inverted outside the done cycle.
`timescale 1ns/1ps
`default_nettype none

module bmv_ee_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Read request
  input  wire logic       req,
  input  wire logic [7:0] addr,
  // Contents and presence
  input  wire logic       present,
  input  wire logic [7:0] b0,
  input  wire logic [7:0] b1,
  input  wire logic [7:0] b4,
  // Answer
  output logic            done,
  output logic            ack,
  output logic [7:0]      data
);
  logic [2:0] cnt_r;
  wire  [7:0] cur = (addr == 8'h00) ? b0 : (addr == 8'h01) ? b1 : b4;
  // Answers a few cycles late; absent part never acknowledges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      done  <= 1'b0;
    end else begin
      done <= (cnt_r == 3'h1);
      if (req) cnt_r <= 3'h3;
      else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
    end
  end
  assign ack  = done & present;
  assign data = done ? cur : ~cur;
endmodule // bmv_ee_model

`default_nettype wire

// ==== bench/bmv_top_tb.sv ====
// Purpose: Self-checking bench of bmv_top.
// Assumes: SAMPLE_CYCLES of 20 to keep the run short.
// Notes:   Inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module bmv_top_tb;
  logic ref_clk = 0, rst_n = 0, en = 1, cs = 0, cv = 0, lv = 0;
  logic [7:0] cb = 8'h00, lb = 8'h00, b0, b1, b4;
  logic pres = 1, done, ack, req;
  logic [7:0] rdat, raddr, desig;
  logic nm, tm, att, run, flt, rst_p, ego, lgo, sgo, fl, dir, drv, oe;
  logic [1:0] spd;
  logic [7:0] len;
  logic [15:0] ctl, ddo;
  logic [63:0] snap;
  // {intrq, vbus, iordy, dmarq, dd}
  logic [19:0] pins = {4'b1110, 16'hbeef};
  int fail_count = 0, n_compared = 0;

  // ****************************************************************
  // Clock and instances
  // ****************************************************************
  initial forever #5 ref_clk = ~ref_clk;
  bmv_ee_model bmv_ee_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .req(req), .addr(raddr), .present(pres), .b0(b0), .b1(b1), .b4(b4),
    .done(done), .ack(ack), .data(rdat));
  bmv_top #(.SAMPLE_CYCLES(20)) bmv_top_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .ata_bus_enable_in(en), .ee_rd_req_r(req),
    .ee_rd_addr_r(raddr), .ee_rd_done(done), .ee_rd_ack(ack),
    .ee_rd_data(rdat), .cbw_start(cs), .cbw_valid(cv), .cbw_byte(cb),
    .load_valid(lv), .load_byte(lb), .intrq_in(pins[19]),
    .vbus_valid_in(pins[18]), .iordy_in(pins[17]), .dmarq_in(pins[16]),
    .dd_in(pins[15:0]), .normal_mode_r(nm), .test_mode_r(tm),
    .usb_attach_r(att), .usb_speed_cap_r(spd), .ata_run_r(run),
    .ata_float_r(flt), .restart_r(rst_p), .desig_r(desig),
    .vcmd_eeprom_go_r(ego), .vcmd_load_go_r(lgo),
    .vcmd_sample_go_r(sgo), .vcmd_fail_r(fl), .vcmd_dir_in_r(dir),
    .vcmd_len_r(len), .test_drive_r(drv), .test_ctrl_r(ctl),
    .test_dd_out_r(ddo), .test_dd_oe_r(oe), .snapshot_r(snap));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Reset, then boot from the model until a mode is chosen
  task automatic boot(input logic p, input logic [7:0] s, input logic [7:0] d);
    pres = p; b0 = 8'h4d; b1 = s; b4 = d; rst_n = 0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1;
    for (int i = 0; i < 60 && !(nm === 1'b1 || tm === 1'b1); i++)
      @(negedge ref_clk);
    // Attach follows the mode decision by one cycle
    @(negedge ref_clk);
  endtask

  // Send a wrapper and collect the outcome pulses {eeprom,load,sample,fail}
  task automatic cmd(input logic [7:0] dg, input logic [7:0] sub,
                     input logic [31:0] ln, input logic di,
                     output logic [3:0] res);
    res = 4'h0;
    for (int i = 0; i < 31; i++) begin
      @(negedge ref_clk);
      cs = (i == 0); cv = 1;
      cb = (i >= 8 && i <= 11) ? ln[8*(i-8) +: 8] : (i == 12) ? {di, 7'h0} :
           (i == 15) ? dg : (i == 16) ? sub :
           (i == 18 && sub == 8'h26) ? 8'h02 : 8'h00;
    end
    @(negedge ref_clk);
    cs = 0; cv = 0;
    repeat (6) begin
      @(negedge ref_clk);
      res = res | {ego, lgo, sgo, fl};
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_normal();
    logic [3:0] r;
    boot(1, 8'h4d, 8'h33);
    chk({nm, tm, att, spd, desig}, {5'b10111, 8'h33});
    cmd(8'h33, 8'h26, 32'hff, 1, r);
    chk({r, dir, len}, {4'h8, 1'b1, 8'hff});
    cmd(8'h33, 8'h26, 32'h100, 0, r);
    chk(r, 4'h1);
    cmd(8'h34, 8'h26, 32'h10, 0, r);
    chk(r, 4'h1);
    cmd(8'h33, 8'h28, 32'h10, 0, r);
    chk(r, 4'h1);
    cmd(8'h33, 8'h27, 32'h8, 1, r);
    chk(r, 4'h1);
  endtask

  task automatic t_enable();
    logic seen;
    seen = 0;
    chk({run, flt}, 2'b10);
    @(negedge ref_clk) en = 0;
    for (int i = 0; i < 40 && flt !== 1'b1; i++) @(negedge ref_clk);
    chk({flt, att, run}, 3'b100);
    @(negedge ref_clk) en = 1;
    for (int i = 0; i < 120 && !(seen && att === 1'b1); i++) begin
      @(negedge ref_clk);
      seen = seen | (rst_p === 1'b1);
    end
    chk({seen, att}, 2'b11);
  endtask

  task automatic t_test();
    logic [3:0] r;
    boot(1, 8'h4c, 8'h5b);
    chk({nm, tm, att, desig}, {3'b011, 8'h5b});
    boot(0, 8'h4d, 8'h33);
    chk({nm, tm, att, desig}, {3'b011, 8'h5a});
    cmd(8'h5a, 8'h27, 32'h8, 1, r);
    chk({r, snap & 64'hffff_b8c1}, {4'h2, 64'hbeef_2841});
    cmd(8'h5a, 8'h27, 32'h7, 0, r);
    chk(r, 4'h4);
    for (int i = 0; i < 7; i++) begin
      @(negedge ref_clk);
      lv = 1;
      lb = (i == 0) ? 8'h80 : (i == 1) ? 8'h85 : (i == 2) ? 8'h34 :
           (i == 3) ? 8'h12 : 8'h00;
    end
    @(negedge ref_clk) lv = 0;
    repeat (2) @(negedge ref_clk);
    chk({drv, oe, ctl, ddo}, {2'b11, 32'h8580_1234});
    pins = {4'b0101, 16'h1234};
    cmd(8'h5a, 8'h27, 32'h8, 1, r);
    chk({r, snap & 64'hffff_b8c1}, {4'h2, 64'h1234_b0c0});
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    en = 1;
    t_normal();
    t_enable();
    t_test();
    end_sim();
  end

  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule // bmv_top_tb

`default_nettype wire
